// ===== pkg/dcfft_pkg.sv
// shared constants, configuration codes and mode decode helpers
package dcfft_pkg;
   localparam int FIFO_WORD_W = 18;
   localparam int FIFO_DEPTH = 4096;
   localparam int OFFSET_W = 13;
   localparam int CFG_W = 3;
   // configuration pins as {first_load_sel, read_expand_in, write_expand_in}
   localparam logic [CFG_W-1:0] CFG_STD_ASYNC = 3'h0;
   localparam logic [CFG_W-1:0] CFG_FALL_THROUGH_MODE_ASYNC = 3'h1;
   localparam logic [CFG_W-1:0] CFG_DBL_ASYNC = 3'h2;
   localparam logic [CFG_W-1:0] CFG_EXP_FIRST = 3'h3;
   localparam logic [CFG_W-1:0] CFG_STD_SYNC = 3'h4;
   localparam logic [CFG_W-1:0] CFG_FALL_THROUGH_MODE_SYNC = 3'h5;
   localparam logic [CFG_W-1:0] CFG_DBL_SYNC = 3'h6;
   localparam logic [CFG_W-1:0] CFG_EXP_NEXT = 3'h7;
   // mode report bits
   localparam int MODE_W = 4;
   localparam int MODE_FALL_THROUGH_MODE = 0;
   localparam int MODE_DOUBLE = 1;
   localparam int MODE_SYNC_PF = 2;
   localparam int MODE_SINGLE = 3;
   // controller register map, byte addresses
   localparam int WB_ADR_W = 8;
   localparam int WB_DAT_W = 32;
   localparam logic [WB_ADR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [WB_ADR_W-1:0] REG_WDATA = 8'h04;
   localparam logic [WB_ADR_W-1:0] REG_RDATA = 8'h08;
   localparam logic [WB_ADR_W-1:0] REG_RCMD = 8'h0C;
   localparam logic [WB_ADR_W-1:0] REG_STATUS = 8'h10;
   localparam int CTRL_W = 4;
   localparam int CTRL_RESET_BIT = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET_VALUE = 4'h0;
   localparam int ST_EMPTY_N = 0;
   localparam int ST_FULL_N = 1;
   localparam int ST_OR_N = 2;
   localparam int ST_IR_N = 3;
   localparam int ST_AE_N = 4;
   localparam int ST_AF_N = 5;
   localparam int ST_WR_PEND = 6;
   localparam int ST_RD_PEND = 7;
   // link clock half periods in CLK cycles
   localparam int WCLK_HALF_DEFAULT = 2;
   localparam int RCLK_HALF_DEFAULT = 3;
   localparam int HALF_MIN = 2;

   function automatic logic cfg_is_fall_through_mode(input logic [CFG_W-1:0] c);
      return c == CFG_FALL_THROUGH_MODE_ASYNC || c == CFG_FALL_THROUGH_MODE_SYNC;
   endfunction

   function automatic logic cfg_is_double(input logic [CFG_W-1:0] c);
      return c == CFG_DBL_ASYNC || c == CFG_DBL_SYNC;
   endfunction

   function automatic logic cfg_is_sync_pf(input logic [CFG_W-1:0] c);
      return c == CFG_STD_SYNC || c == CFG_FALL_THROUGH_MODE_SYNC || c == CFG_DBL_SYNC;
   endfunction

   function automatic logic cfg_is_single(input logic [CFG_W-1:0] c);
      return c != CFG_EXP_FIRST && c != CFG_EXP_NEXT;
   endfunction
endpackage

// ===== pkg/dcfft_link_if.sv
// link between the fifo device and its controller
`timescale 1ns/1ps
interface dcfft_link_if;
   import dcfft_pkg::*;
   logic wclk;
   logic rclk;
   logic wen_n;
   logic ren_n;
   logic [FIFO_WORD_W-1:0] d;
   logic [FIFO_WORD_W-1:0] q;
   logic empty_indicator_n;
   logic full_indicator_n;
   logic output_ready_n;
   logic input_ready_n;
   logic almost_empty_n;
   logic almost_full_n;
   logic first_load_sel;
   logic read_expand_in;
   logic write_expand_in;
   logic master_reset;

   modport dev
   (
      input wclk, rclk, wen_n, ren_n, d, first_load_sel, read_expand_in,
      input write_expand_in, master_reset,
      output q, empty_indicator_n, full_indicator_n, output_ready_n,
      output input_ready_n, almost_empty_n, almost_full_n
   );

   modport host
   (
      output wclk, rclk, wen_n, ren_n, d, first_load_sel, read_expand_in,
      output write_expand_in, master_reset,
      input q, empty_indicator_n, full_indicator_n, output_ready_n,
      input input_ready_n, almost_empty_n, almost_full_n
   );
endinterface

// ===== rtl/dcfft_edge.sv
// rising edge detector for a link clock sampled on CLK
`timescale 1ns/1ps
module dcfft_edge
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic level,
   output logic rise
);
   logic prev;

   // prev starts high so a clock already high at reset gives no edge
   always_ff @(posedge clk)
   begin
      if (rst)
         prev <= 1'b1;
      else if (ce)
         prev <= level;
   end

   assign rise = ce & level & ~prev;
endmodule

// ===== rtl/dcfft_device.sv
// fifo device end: storage, mode decode and flag timing
`timescale 1ns/1ps
module dcfft_device
   import dcfft_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [OFFSET_W-1:0] AE_OFFSET,
   input wire logic [OFFSET_W-1:0] AF_OFFSET,
   output logic [MODE_W-1:0] MODE,
   dcfft_link_if.dev LINK
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
   localparam logic [OFFSET_W-1:0] DEPTH_O = OFFSET_W'(DEPTH);

   if (DEPTH < 4 || DEPTH > FIFO_DEPTH || (1 << AW) != DEPTH)
   begin : g_depth_check
      $error("DEPTH must be a power of two from 4 to the package depth");
   end

   logic [FIFO_WORD_W-1:0] store [DEPTH];
   logic [FIFO_WORD_W-1:0] q;
   logic [PW-1:0] wptr;
   logic [PW-1:0] rptr;
   logic [PW-1:0] next_wptr;
   logic [PW-1:0] next_rptr;
   logic [CFG_W-1:0] cfg;
   logic in_reset;
   logic wtick;
   logic rtick;
   logic fall_through_mode;
   logic dbl;
   logic sync_pf;
   logic full_s;
   logic full_d;
   logic empty_s;
   logic empty_d;
   logic full_shown;
   logic empty_shown;
   logic next_full;
   logic next_empty;
   logic ne1;
   logic out_full;
   logic next_out_full;
   logic do_write;
   logic do_read;
   logic consume;
   logic load_out;
   logic ae_n;
   logic af_n;
   logic [OFFSET_W-1:0] fill_w;
   logic [OFFSET_W-1:0] fill_r;
   logic [OFFSET_W-1:0] fill_all;
   logic [OFFSET_W-1:0] depth_eff;

   function automatic logic [OFFSET_W-1:0] fill_of(input logic [PW-1:0] wp,
      input logic [PW-1:0] rp, input logic extra);
      logic [PW-1:0] diff;
      diff = wp - rp;
      return OFFSET_W'(diff) + OFFSET_W'(extra);
   endfunction

   assign in_reset = RST | LINK.master_reset;

   dcfft_edge u_wedge
   (
      .clk(CLK),
      .rst(in_reset),
      .ce(CE),
      .level(LINK.wclk),
      .rise(wtick)
   );

   dcfft_edge u_redge
   (
      .clk(CLK),
      .rst(in_reset),
      .ce(CE),
      .level(LINK.rclk),
      .rise(rtick)
   );

   // pins are caught on every reset cycle so the last one before release wins
   always_ff @(posedge CLK)
   begin
      if (in_reset)
         cfg <= {LINK.first_load_sel, LINK.read_expand_in,
            LINK.write_expand_in};
   end

   assign fall_through_mode = cfg_is_fall_through_mode(cfg);
   assign dbl = cfg_is_double(cfg);
   assign sync_pf = cfg_is_sync_pf(cfg);
   assign MODE = {cfg_is_single(cfg), sync_pf, dbl, fall_through_mode};

   // fall-through shows the double stage, standard the chosen buffering
   assign full_shown = (fall_through_mode | dbl) ? full_d : full_s;
   assign empty_shown = dbl ? empty_d : empty_s;

   assign do_write = wtick & ~LINK.wen_n & ~full_shown;
   assign do_read = rtick & ~fall_through_mode & ~LINK.ren_n & ~empty_shown;
   assign consume = rtick & fall_through_mode & ~LINK.ren_n & out_full;
   assign load_out = rtick & fall_through_mode & ne1 & (~out_full | consume);
   assign next_out_full = load_out | (out_full & ~consume);
   assign next_wptr = wptr + PW'(do_write);
   assign next_rptr = rptr + PW'(do_read | load_out);
   assign next_full = (next_wptr - rptr) == DEPTH_P;
   assign next_empty = wptr == next_rptr;

   always_ff @(posedge CLK)
   begin
      if (do_write)
         store[wptr[AW-1:0]] <= LINK.d;
   end

   always_ff @(posedge CLK)
   begin
      if (in_reset)
      begin
         wptr <= '0;
         rptr <= '0;
      end
      else if (CE)
      begin
         wptr <= next_wptr;
         rptr <= next_rptr;
      end
   end

   // output word: moved on a read, or on its own in fall-through mode
   always_ff @(posedge CLK)
   begin
      if (in_reset)
         q <= '0;
      else if (do_read | load_out)
         q <= store[rptr[AW-1:0]];
   end

   // full side: a read in the same CLK cycle as a write edge is missed and
   // only seen at the following write edge, which models the skew minimum
   always_ff @(posedge CLK)
   begin
      if (in_reset)
      begin
         full_s <= 1'b0;
         full_d <= 1'b1;
      end
      else if (wtick)
      begin
         full_s <= next_full;
         full_d <= next_full | full_s;
      end
   end

   // empty side sees writes from earlier cycles only
   always_ff @(posedge CLK)
   begin
      if (in_reset)
      begin
         empty_s <= 1'b1;
         empty_d <= 1'b1;
      end
      else if (rtick)
      begin
         empty_s <= next_empty;
         empty_d <= next_empty | empty_s;
      end
   end

   // fall-through: sense stage, then the output register stage
   always_ff @(posedge CLK)
   begin
      if (in_reset)
      begin
         ne1 <= 1'b0;
         out_full <= 1'b0;
      end
      else if (rtick)
      begin
         ne1 <= ~next_empty & fall_through_mode;
         out_full <= next_out_full;
      end
   end

   // partial flag fill levels; none depends on the buffering choice
   assign depth_eff = DEPTH_O + OFFSET_W'(fall_through_mode);
   assign fill_w = fill_of(next_wptr, rptr, out_full);
   assign fill_r = fill_of(wptr, next_rptr, next_out_full);
   assign fill_all = fill_of(next_wptr, next_rptr, next_out_full);

   always_ff @(posedge CLK)
   begin
      if (in_reset)
         ae_n <= 1'b0;
      else if (sync_pf)
      begin
         if (rtick)
            ae_n <= ~(fill_r <= AE_OFFSET);
      end
      else if (rtick & (fill_all <= AE_OFFSET))
         ae_n <= 1'b0;
      else if (wtick & ~(fill_all <= AE_OFFSET))
         ae_n <= 1'b1;
   end

   always_ff @(posedge CLK)
   begin
      if (in_reset)
         af_n <= 1'b1;
      else if (sync_pf)
      begin
         if (wtick)
            af_n <= ~((depth_eff - fill_w) <= AF_OFFSET);
      end
      else if (wtick & ((depth_eff - fill_all) <= AF_OFFSET))
         af_n <= 1'b0;
      else if (rtick & ~((depth_eff - fill_all) <= AF_OFFSET))
         af_n <= 1'b1;
   end

   // pins of the mode not selected rest high
   assign LINK.q = q;
   assign LINK.empty_indicator_n = fall_through_mode | ~empty_shown;
   assign LINK.full_indicator_n = fall_through_mode | ~full_shown;
   assign LINK.output_ready_n = ~fall_through_mode | ~out_full;
   assign LINK.input_ready_n = ~fall_through_mode | full_d;
   assign LINK.almost_empty_n = ae_n;
   assign LINK.almost_full_n = af_n;
endmodule

// ===== rtl/dcfft_host.sv
// controller end: wishbone registers driving the fifo link
`timescale 1ns/1ps
module dcfft_host
   import dcfft_pkg::*;
#(
   parameter int WCLK_HALF = WCLK_HALF_DEFAULT,
   parameter int RCLK_HALF = RCLK_HALF_DEFAULT
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [WB_ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [WB_DAT_W-1:0] WB_DAT_I,
   output logic [WB_DAT_W-1:0] WB_DAT_O,
   output logic WB_ACK_O,
   dcfft_link_if.host LINK
);
   if (WCLK_HALF < HALF_MIN || RCLK_HALF < HALF_MIN)
   begin : g_half_check
      $error("link clock half periods must be at least two cycles");
   end

   logic [15:0] wcnt;
   logic [15:0] rcnt;
   logic wclk;
   logic rclk;
   logic w_fall;
   logic r_fall;
   logic [CTRL_W-1:0] ctrl;
   logic [FIFO_WORD_W-1:0] wbuf;
   logic [FIFO_WORD_W-1:0] rdata;
   logic wr_pend;
   logic rd_pend;
   logic wen_n;
   logic ren_n;
   logic fall_through_mode;
   logic can_write;
   logic can_read;
   logic req;
   logic stall;
   logic bus_wr;
   logic [WB_DAT_W-1:0] status;

   // link clocks come from CLK by dividers; strobes change on their low edge, d on a bus write
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         wcnt <= '0;
         wclk <= 1'b0;
      end
      else if (CE)
      begin
         wcnt <= (wcnt == 16'(WCLK_HALF - 1)) ? '0 : wcnt + 16'h0001;
         if (wcnt == 16'(WCLK_HALF - 1))
            wclk <= ~wclk;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         rcnt <= '0;
         rclk <= 1'b0;
      end
      else if (CE)
      begin
         rcnt <= (rcnt == 16'(RCLK_HALF - 1)) ? '0 : rcnt + 16'h0001;
         if (rcnt == 16'(RCLK_HALF - 1))
            rclk <= ~rclk;
      end
   end

   assign w_fall = CE & wclk & (wcnt == 16'(WCLK_HALF - 1));
   assign r_fall = CE & rclk & (rcnt == 16'(RCLK_HALF - 1));

   assign fall_through_mode = cfg_is_fall_through_mode(ctrl[CFG_W-1:0]);
   // the device refuses writes when full and reads when empty, so the
   // host only strobes when the flag it last saw allows it
   assign can_write = fall_through_mode ? ~LINK.input_ready_n : LINK.full_indicator_n;
   assign can_read = fall_through_mode ? ~LINK.output_ready_n : LINK.empty_indicator_n;

   // a push or pop order waits on the bus while the previous one is open
   assign req = WB_CYC_I & WB_STB_I;
   assign stall = WB_WE_I & (((WB_ADR_I == REG_WDATA) & wr_pend)
      | ((WB_ADR_I == REG_RCMD) & rd_pend));
   assign bus_wr = req & WB_WE_I & WB_ACK_O;

   always_ff @(posedge CLK)
   begin
      if (RST)
         WB_ACK_O <= 1'b0;
      else if (CE)
         WB_ACK_O <= req & ~WB_ACK_O & ~stall;
   end

   always_comb
   begin
      status = '0;
      status[ST_EMPTY_N] = LINK.empty_indicator_n;
      status[ST_FULL_N] = LINK.full_indicator_n;
      status[ST_OR_N] = LINK.output_ready_n;
      status[ST_IR_N] = LINK.input_ready_n;
      status[ST_AE_N] = LINK.almost_empty_n;
      status[ST_AF_N] = LINK.almost_full_n;
      status[ST_WR_PEND] = wr_pend;
      status[ST_RD_PEND] = rd_pend;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         WB_DAT_O <= '0;
      else if (CE & req & ~WB_ACK_O & ~stall)
      begin
         unique case (WB_ADR_I)
            REG_CTRL: WB_DAT_O <= WB_DAT_W'(ctrl);
            REG_RDATA: WB_DAT_O <= WB_DAT_W'(rdata);
            REG_STATUS: WB_DAT_O <= status;
            default: WB_DAT_O <= '0;
         endcase
      end
   end

   // configuration pins only count while master reset is held
   always_ff @(posedge CLK)
   begin
      if (RST)
         ctrl <= CTRL_RESET_VALUE;
      else if (CE & bus_wr & (WB_ADR_I == REG_CTRL) & WB_SEL_I[0])
         ctrl <= WB_DAT_I[CTRL_W-1:0];
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         wr_pend <= 1'b0;
         wbuf <= '0;
      end
      else if (CE)
      begin
         if (bus_wr & (WB_ADR_I == REG_WDATA) & (&WB_SEL_I[2:0]))
         begin
            wr_pend <= 1'b1;
            wbuf <= WB_DAT_I[FIFO_WORD_W-1:0];
         end
         else if (w_fall & ~wen_n)
            wr_pend <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         wen_n <= 1'b1;
      else if (w_fall)
         wen_n <= ~(wen_n & wr_pend & can_write);
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         rd_pend <= 1'b0;
      else if (CE)
      begin
         if (bus_wr & (WB_ADR_I == REG_RCMD) & (|WB_SEL_I))
            rd_pend <= 1'b1;
         else if (r_fall & ~ren_n)
            rd_pend <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         ren_n <= 1'b1;
      else if (r_fall)
         ren_n <= ~(ren_n & rd_pend & can_read);
   end

   // fall-through word is on the pins before the read, standard after it
   always_ff @(posedge CLK)
   begin
      if (RST)
         rdata <= '0;
      else if (r_fall & ~ren_n & ~fall_through_mode)
         rdata <= LINK.q;
      else if (r_fall & ren_n & rd_pend & can_read & fall_through_mode)
         rdata <= LINK.q;
   end

   assign LINK.wclk = wclk;
   assign LINK.rclk = rclk;
   assign LINK.wen_n = wen_n;
   assign LINK.ren_n = ren_n;
   assign LINK.d = wbuf;
   assign LINK.first_load_sel = ctrl[2];
   assign LINK.read_expand_in = ctrl[1];
   assign LINK.write_expand_in = ctrl[0];
   assign LINK.master_reset = ctrl[CTRL_RESET_BIT];
endmodule

// ===== tb/dcfft_flag_properties.sv
// concurrent checks of flag and word timing on the fifo link
`timescale 1ns/1ps
module dcfft_flag_properties
   import dcfft_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic wclk,
   input wire logic rclk,
   input wire logic [FIFO_WORD_W-1:0] q,
   input wire logic empty_indicator_n,
   input wire logic full_indicator_n,
   input wire logic output_ready_n,
   input wire logic input_ready_n,
   input wire logic almost_empty_n,
   input wire logic almost_full_n,
   input wire logic first_load_sel,
   input wire logic read_expand_in,
   input wire logic write_expand_in,
   input wire logic master_reset
);
   logic [2:0] wh;
   logic [2:0] rh;
   logic w_near;
   logic r_near;
   logic sync_pf;
   logic fall_through_mode;

   // history of link clock samples; allows for sampler plus flag flop lag
   always_ff @(posedge CLK)
   begin
      wh <= {wh[1:0], wclk};
      rh <= {rh[1:0], rclk};
   end

   assign w_near = (wclk & ~wh[0]) | (wh[0] & ~wh[1]) | (wh[1] & ~wh[2]);
   assign r_near = (rclk & ~rh[0]) | (rh[0] & ~rh[1]) | (rh[1] & ~rh[2]);
   assign sync_pf = first_load_sel & ~(read_expand_in & write_expand_in);
   assign fall_through_mode = ~read_expand_in & write_expand_in;

   default clocking @(posedge CLK); endclocking
   default disable iff (RST || master_reset);

   a_async_af_low: assert property (
      !sync_pf && $fell(almost_full_n) |-> w_near)
      else $error("almost full asserted away from a write clock rise");
   a_async_af_high: assert property (
      !sync_pf && $rose(almost_full_n) |-> r_near)
      else $error("almost full released away from a read clock rise");
   a_async_ae_low: assert property (
      !sync_pf && $fell(almost_empty_n) |-> r_near)
      else $error("almost empty asserted away from a read clock rise");
   a_async_ae_high: assert property (
      !sync_pf && $rose(almost_empty_n) |-> w_near)
      else $error("almost empty released away from a write clock rise");
   a_sync_ae_edge: assert property (
      sync_pf && $changed(almost_empty_n) |-> r_near)
      else $error("sync almost empty moved off a read clock rise");
   a_sync_af_edge: assert property (
      sync_pf && $changed(almost_full_n) |-> w_near)
      else $error("sync almost full moved off a write clock rise");
   a_std_ready_idle: assert property (
      !fall_through_mode |-> output_ready_n && input_ready_n)
      else $error("ready flags active in standard mode");
   a_fall_through_mode_flag_idle: assert property (
      fall_through_mode |-> empty_indicator_n && full_indicator_n)
      else $error("empty or full flag active in fall-through mode");
   a_empty_clear_edge: assert property (
      !fall_through_mode && $rose(empty_indicator_n) |-> r_near)
      else $error("empty flag cleared away from a read clock rise");
   a_full_clear_edge: assert property (
      !fall_through_mode && $rose(full_indicator_n) |-> w_near)
      else $error("full flag cleared away from a write clock rise");
   a_out_ready_edge: assert property (
      fall_through_mode && $fell(output_ready_n) |-> r_near)
      else $error("output ready asserted away from a read clock rise");
   a_in_ready_edge: assert property (
      fall_through_mode && $fell(input_ready_n) |-> w_near)
      else $error("input ready asserted away from a write clock rise");
   a_word_on_read: assert property (
      $changed(q) |-> r_near)
      else $error("output word moved away from a read clock rise");

   c_ae_release: cover property ($rose(almost_empty_n));
   c_af_assert: cover property ($fell(almost_full_n));
   c_word_ready: cover property (fall_through_mode && $fell(output_ready_n));
endmodule

// ===== tb/tb.sv
// self-checking bench: controller and fifo device joined over the link
`timescale 1ns/1ps
module tb;
   import dcfft_pkg::*;
   localparam int DEPTH = 8;
   localparam int LIMIT = 60000;
   logic CLK;
   logic RST;
   logic cyc;
   logic stb;
   logic we;
   logic [3:0] sel;
   logic [WB_ADR_W-1:0] adr;
   logic [WB_DAT_W-1:0] wdat;
   logic [WB_DAT_W-1:0] rdat;
   logic ack;
   logic [OFFSET_W-1:0] ae_off;
   logic [OFFSET_W-1:0] af_off;
   logic [MODE_W-1:0] mode;
   int n_fail;
   int comparisons;
   int cycles;
   int model[$];

   dcfft_link_if i_dcfft_link_if();

   dcfft_device #(.DEPTH(DEPTH)) i_dcfft_device
   (
      .CLK(CLK), .RST(RST), .CE(1'h1), .AE_OFFSET(ae_off),
      .AF_OFFSET(af_off), .MODE(mode), .LINK(i_dcfft_link_if.dev)
   );

   // slow link clocks keep the edge windows of the checker narrow
   dcfft_host #(.WCLK_HALF(4), .RCLK_HALF(7)) i_dcfft_host
   (
      .CLK(CLK), .RST(RST), .CE(1'h1), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .LINK(i_dcfft_link_if.host)
   );

   dcfft_flag_properties i_dcfft_flag_properties
   (
      .CLK(CLK), .RST(RST), .wclk(i_dcfft_link_if.wclk),
      .rclk(i_dcfft_link_if.rclk), .q(i_dcfft_link_if.q),
      .empty_indicator_n(i_dcfft_link_if.empty_indicator_n),
      .full_indicator_n(i_dcfft_link_if.full_indicator_n),
      .output_ready_n(i_dcfft_link_if.output_ready_n),
      .input_ready_n(i_dcfft_link_if.input_ready_n),
      .almost_empty_n(i_dcfft_link_if.almost_empty_n),
      .almost_full_n(i_dcfft_link_if.almost_full_n),
      .first_load_sel(i_dcfft_link_if.first_load_sel),
      .read_expand_in(i_dcfft_link_if.read_expand_in),
      .write_expand_in(i_dcfft_link_if.write_expand_in),
      .master_reset(i_dcfft_link_if.master_reset)
   );

   always #2 CLK = ~CLK;

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic wb(input logic w, input logic [WB_ADR_W-1:0] a,
      input logic [WB_DAT_W-1:0] d, output logic [WB_DAT_W-1:0] r);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= d;
      @(posedge CLK);
      while (ack !== 1'h1)
         @(posedge CLK);
      r = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge CLK);
   endtask

   task automatic note(input string what, input logic [WB_DAT_W-1:0] e,
      input logic [WB_DAT_W-1:0] s);
      comparisons++;
      if (s !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic check_word(input logic [WB_DAT_W-1:0] e,
      input logic [WB_DAT_W-1:0] s);
      note("read word", e, s);
   endtask

   task automatic check_mode(input logic [2:0] c);
      logic x;
      x = c[1] & c[0];
      note("mode", {28'h0, !x, c[2] & !x, c[1] & !c[0], !c[1] & c[0]},
         {28'h0, mode});
   endtask

   // flags settle a few link edges after the pending bits clear
   task automatic check_flags(input logic [5:0] e);
      logic [WB_DAT_W-1:0] s;
      int n;
      n = 0;
      wb(1'h0, REG_STATUS, 32'h0, s);
      while (s[5:0] !== e && n < 60)
      begin
         wb(1'h0, REG_STATUS, 32'h0, s);
         n++;
      end
      note("status flags", {26'h0, e}, {26'h0, s[5:0]});
   endtask

   task automatic wait_idle();
      logic [WB_DAT_W-1:0] s;
      int n;
      n = 0;
      s = 32'hFFFFFFFF;
      while ((s[ST_WR_PEND] | s[ST_RD_PEND]) !== 1'h0 && n < 100)
      begin
         wb(1'h0, REG_STATUS, 32'h0, s);
         n++;
      end
   endtask

   // {af_n, ae_n, ir_n, or_n, full_n, empty_n} for n stored words
   function automatic logic [5:0] exp_flags(input logic [2:0] c, input int n);
      logic f;
      int d;
      f = !c[1] && c[0];
      d = f ? DEPTH + 1 : DEPTH;
      return {d - n > af_off, n > ae_off, !f || n == d, !f || n == 0,
         f || n != d, f || n != 0};
   endfunction

   initial
   begin
      logic [WB_DAT_W-1:0] r;
      logic [FIFO_WORD_W-1:0] w;
      int d;
      CLK = 1'h0;
      RST = 1'h1;
      cyc = 1'h0;
      stb = 1'h0;
      we = 1'h0;
      sel = 4'h0;
      adr = 8'h00;
      wdat = 32'h0;
      ae_off = 13'h0;
      af_off = 13'h0;
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      void'($urandom(70));
      repeat (12) @(posedge CLK);
      RST <= 1'h0;
      @(posedge CLK);
      wb(1'h0, 8'h14, 32'h0, r);
      check_word(32'h0, r);
      for (int c = 0; c < 8; c++)
      begin
         wb(1'h1, REG_CTRL, 32'(8 + c), r);
         ae_off <= OFFSET_W'($urandom_range(1, 3));
         af_off <= OFFSET_W'($urandom_range(1, 3));
         wb(1'h1, REG_CTRL, 32'(c), r);
         check_mode(3'(c));
         d = (!c[1] && c[0]) ? DEPTH + 1 : DEPTH;
         check_flags(exp_flags(3'(c), 0));
         repeat (d)
         begin
            w = FIFO_WORD_W'($urandom);
            wb(1'h1, REG_WDATA, 32'(w), r);
            model.push_back(w);
            wait_idle();
            check_flags(exp_flags(3'(c), model.size()));
         end
         while (model.size() > 0)
         begin
            wb(1'h1, REG_RCMD, 32'h0, r);
            wait_idle();
            wb(1'h0, REG_RDATA, 32'h0, r);
            check_word(32'(model.pop_front()), r);
            check_flags(exp_flags(3'(c), model.size()));
         end
         $display("configuration %0d done", c);
      end
      tally_and_finish();
   end
endmodule
